// *** design/mdp_acc_shifter.sv ***
`timescale 1ns/10ps
module mdp_acc_shifter #(
	parameter int SHIFT_MAX = 16
) (
	input wire logic [39:0] d_i,
	input wire logic left_i,
	input wire logic [4:0] amt_i,
	output logic [39:0] q_o,
	output logic lost_o
);
	// ****************************************
	// arithmetic left/right shift, 0..SHIFT_MAX
	// ****************************************
	// refused at elaboration: the 56-bit window only covers 16 places
	if (SHIFT_MAX < 1 || SHIFT_MAX > 16) begin : g_bad_shift_max
		$error("mdp_acc_shifter: SHIFT_MAX out of range");
	end

	logic [55:0] ext;
	logic [55:0] wide;

	always_comb begin
		ext = {{16{d_i[39]}}, d_i};
		wide = ext << amt_i;
		if (amt_i == 5'h00) begin
			q_o = d_i;
			lost_o = 1'b0;
		end else if (left_i) begin
			q_o = wide[39:0];
			// significant bits pushed past bit 39
			lost_o = !((&wide[55:39]) || (~|wide[55:39]));
		end else begin
			q_o = 40'($signed(d_i) >>> amt_i);
			lost_o = 1'b0;
		end
	end
endmodule // mdp_acc_shifter

// *** design/mdp_consts.svh ***
`ifndef MDP_CONSTS_SVH
`define MDP_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define MDP_OFS_CTRL 8'h00
`define MDP_OFS_STATUS 8'h04
`define MDP_OFS_ACC_HIGH 8'h08
`define MDP_OFS_ACC_LOW 8'h0C
`define MDP_OFS_OPND_A 8'h10
`define MDP_OFS_OPND_B 8'h14
`define MDP_OFS_CMD 8'h18
`define MDP_OFS_STORE 8'h1C

// ****************************************
// control word fields
// ****************************************
`define MDP_CTRL_RESET 16'h0000
`define MDP_CTRL_MP_BIT 10
`define MDP_CTRL_MS_BIT 9

// ****************************************
// status word fields
// ****************************************
`define MDP_ST_N_BIT 8
`define MDP_ST_Z_BIT 9
`define MDP_ST_C_BIT 10
`define MDP_ST_SV_BIT 11
`define MDP_ST_E_BIT 12
`define MDP_ST_SL_BIT 13
`define MDP_ST_V_BIT 14

// ****************************************
// command word fields
// ****************************************
`define MDP_CMD_OP_LSB 0
`define MDP_CMD_OP_W 4
`define MDP_CMD_ASGN_BIT 4
`define MDP_CMD_BSGN_BIT 5
`define MDP_CMD_RND_BIT 6
`define MDP_CMD_CSCL_BIT 7
`define MDP_CMD_SDIR_BIT 8
`define MDP_CMD_SAMT_LSB 9
`define MDP_CMD_SAMT_W 5

// ****************************************
// arithmetic constants
// ****************************************
`define MDP_SHIFT_MAX 16
`define MDP_RND_ADD 40'h0000008000
`define MDP_SAT_POS 40'h007FFFFFFF
`define MDP_SAT_NEG 40'hFF80000000
`define MDP_LIM_POS 16'h7FFF
`define MDP_LIM_NEG 16'h8000

`endif

// *** design/mdp_mac_datapath.sv ***
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "mdp_consts.svh"
// How it works
// [RQ1] operands are two's complement, msb is the sign
// [RQ2] unsigned operands only for multiply and mac, chosen per operand
// [RQ3] fractional 1.15 operands supported when product shift enable is set
// [RQ4] rounding adds 0x8000 to the 40-bit result then clears low word
// [RQ5] 16x16 signed/unsigned multiply completes in one cycle
// [RQ6] product is always delivered as a signed value
// [RQ7] two 16-bit operands joined to 32 bits, combined with accumulator
// [RQ8] joined 32-bit operand can preload the accumulator
// [RQ9] scaler shifts joined operand or product left one bit
// [RQ10] product shift enable plus both signed shifts product left one
// [RQ11] adder takes shifted accumulator and sign-extended scaler operand
// [RQ12] saturation enable saturates accumulator to 32 bits after each op; load and right shifts are never saturated
// [RQ13] saturation loads 0x007FFFFFFF or 0xFF80000000 by overflow direction
// [RQ14] limited view: unchanged if extension clear, else 7FFF or 8000
// [RQ15] limiting leaves accumulator and status untouched; store only
// [RQ16] accumulator shifter: 40 in, 40 out, none or up to 16 arith
// [RQ17] left shifts update extension, sticky flags, saturate like adder
// [RQ18] accumulator is extension byte over high and low words
// [RQ19] extension flag set when top nine bits differ
// [RQ20] writing high word clears low word and sign-fills extension
// [RQ21] rounding happens before saturation
// [RQ22] negative flag is the accumulator's bit 39
module mdp_mac_datapath
	import mdp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			r[15:8] = dat[15:8];
		end
		return r;
	endfunction

	function automatic logic ext_used(input logic [39:0] v);
		return !((&v[39:31]) || (~|v[39:31])); // RQ19
	endfunction

	mdp_state_t st;
	mdp_state_t next_st;

	// ****************************************
	// bus qualifiers
	// ****************************************
	logic req;
	logic wr;
	logic [31:0] cmd;
	mdp_op_t op;
	logic a_sgn;
	logic b_sgn;
	logic rnd;
	logic cscl;
	logic sh_left;
	logic [4:0] sh_amt;

	assign req = wb_cyc_i && wb_stb_i;
	// write lands at the edge where the master sees ack
	assign wr = req && wb_we_i && st.ack;
	assign cmd = wb_dat_i;
	assign a_sgn = cmd[`MDP_CMD_ASGN_BIT];
	assign b_sgn = cmd[`MDP_CMD_BSGN_BIT];
	assign rnd = cmd[`MDP_CMD_RND_BIT];
	assign cscl = cmd[`MDP_CMD_CSCL_BIT];
	assign sh_left = !cmd[`MDP_CMD_SDIR_BIT];

	always_comb begin
		op = MDP_OP_NOP;
		if (wr && wb_adr_i == `MDP_OFS_CMD) begin
			if (cmd[`MDP_CMD_OP_LSB +: `MDP_CMD_OP_W] <= 4'h8) begin
				op = mdp_op_t'(cmd[`MDP_CMD_OP_LSB +: `MDP_CMD_OP_W]);
			end
		end
		sh_amt = cmd[`MDP_CMD_SAMT_LSB +: `MDP_CMD_SAMT_W];
		// counts past the shifter's reach are clamped, not refused
		if (sh_amt > 5'(`MDP_SHIFT_MAX)) begin
			sh_amt = 5'(`MDP_SHIFT_MAX);
		end
	end

	// ****************************************
	// multiplier and scaler
	// ****************************************
	logic signed [33:0] prod;
	logic [39:0] prod_op;
	logic [39:0] cat_op;

	always_comb begin
		// per-operand sign extension picks the interpretation
		prod = $signed({a_sgn & st.opa[15], st.opa}) *
			$signed({b_sgn & st.opb[15], st.opb}); // RQ2 RQ5
		prod_op = {{6{prod[33]}}, prod}; // RQ6
		if (st.mp && a_sgn && b_sgn) begin
			prod_op = {prod_op[38:0], 1'b0}; // RQ3 RQ9 RQ10
		end
		cat_op = {{8{st.opb[15]}}, st.opb, st.opa}; // RQ1 RQ7
		if (cscl) begin
			cat_op = {cat_op[38:0], 1'b0}; // RQ9
		end
	end

	// ****************************************
	// accumulator shifter
	// ****************************************
	logic [39:0] sh_q;
	logic sh_lost;

	mdp_acc_shifter #(
		.SHIFT_MAX(`MDP_SHIFT_MAX)
	) u_shifter (
		.d_i(st.acc),
		.left_i(sh_left),
		.amt_i(sh_amt),
		.q_o(sh_q),
		.lost_o(sh_lost)
	); // RQ16

	// ****************************************
	// adder/subtracter, round, saturate
	// ****************************************
	logic [39:0] fb;
	logic [39:0] opnd;
	logic sub;
	logic [40:0] sum41;
	logic [40:0] usum;
	logic [39:0] res;
	logic ovf;
	logic carry;
	logic sat;
	logic sat_neg;
	logic arith;

	always_comb begin
		arith = 1'b1;
		sub = 1'b0;
		fb = sh_q; // RQ11
		opnd = prod_op;
		case (op)
			MDP_OP_MUL: begin
				fb = 40'h0000000000;
			end
			MDP_OP_MAC: begin
				sub = 1'b0;
			end
			MDP_OP_MSUB: begin
				sub = 1'b1;
			end
			MDP_OP_CADD: begin
				opnd = cat_op;
			end
			MDP_OP_CSUB: begin
				opnd = cat_op;
				sub = 1'b1;
			end
			default: begin
				arith = 1'b0;
			end
		endcase
		if (sub) begin
			sum41 = {fb[39], fb} - {opnd[39], opnd};
			usum = {1'b0, fb} - {1'b0, opnd};
		end else begin
			sum41 = {fb[39], fb} + {opnd[39], opnd}; // RQ7 RQ11
			usum = {1'b0, fb} + {1'b0, opnd};
		end
		ovf = sum41[40] ^ sum41[39];
		carry = usum[40];
		res = sum41[39:0];
		sat_neg = sum41[40];
		if (rnd) begin
			res = res + `MDP_RND_ADD; // RQ4 RQ21
			res[15:0] = 16'h0000; // RQ4
			sat_neg = ovf ? sum41[40] : res[39];
		end else if (!ovf) begin
			sat_neg = res[39];
		end
		if (op == MDP_OP_SHIFT) begin
			res = sh_q;
			ovf = sh_lost; // RQ17
			carry = 1'b0;
			sat_neg = sh_lost ? st.acc[39] : sh_q[39];
		end
		// a wrapped 40-bit sum has lost its sign, so ovf steers direction
		sat = st.ms && (ovf || ext_used(res)) &&
			(arith || (op == MDP_OP_SHIFT && sh_left)); // RQ12 RQ17
		if (sat) begin
			res = sat_neg ? `MDP_SAT_NEG : `MDP_SAT_POS; // RQ13
		end
	end

	// ****************************************
	// data limiter
	// ****************************************
	logic [15:0] limited;

	always_comb begin
		if (!st.f_e) begin
			limited = st.acc[31:16]; // RQ14
		end else if (!st.acc[39]) begin
			limited = `MDP_LIM_POS; // RQ14 RQ22
		end else begin
			limited = `MDP_LIM_NEG; // RQ14 RQ22
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	logic [15:0] status_word;
	logic [15:0] ctrl_word;
	logic [31:0] rd;

	always_comb begin
		status_word = 16'h0000;
		status_word[7:0] = st.acc[39:32]; // RQ18
		status_word[`MDP_ST_N_BIT] = st.f_n;
		status_word[`MDP_ST_Z_BIT] = st.f_z;
		status_word[`MDP_ST_C_BIT] = st.f_c;
		status_word[`MDP_ST_SV_BIT] = st.f_sv;
		status_word[`MDP_ST_E_BIT] = st.f_e;
		status_word[`MDP_ST_SL_BIT] = st.f_sl;
		status_word[`MDP_ST_V_BIT] = st.f_v;
		ctrl_word = `MDP_CTRL_RESET;
		ctrl_word[`MDP_CTRL_MP_BIT] = st.mp;
		ctrl_word[`MDP_CTRL_MS_BIT] = st.ms;
		rd = 32'h00000000;
		if (wb_adr_i == `MDP_OFS_CTRL) begin
			rd[15:0] = ctrl_word;
		end else if (wb_adr_i == `MDP_OFS_STATUS) begin
			rd[15:0] = status_word;
		end else if (wb_adr_i == `MDP_OFS_ACC_HIGH) begin
			rd[15:0] = st.acc[31:16];
		end else if (wb_adr_i == `MDP_OFS_ACC_LOW) begin
			rd[15:0] = st.acc[15:0];
		end else if (wb_adr_i == `MDP_OFS_OPND_A) begin
			rd[15:0] = st.opa;
		end else if (wb_adr_i == `MDP_OFS_OPND_B) begin
			rd[15:0] = st.opb;
		end else if (wb_adr_i == `MDP_OFS_STORE) begin
			rd[15:0] = st.store; // RQ15
		end
	end

	// ****************************************
	// next state
	// ****************************************
	logic [15:0] hw;
	logic [15:0] sw;

	always_comb begin
		next_st = st;
		hw = 16'h0000;
		sw = 16'h0000;
		// single-cycle ack; drops the cycle after it was given
		next_st.ack = req && !st.ack;
		if (req && !st.ack) begin
			next_st.rdata = rd;
		end
		if (wr) begin
			if (wb_adr_i == `MDP_OFS_CTRL) begin
				if (wb_sel_i[1]) begin
					next_st.mp = wb_dat_i[`MDP_CTRL_MP_BIT];
					next_st.ms = wb_dat_i[`MDP_CTRL_MS_BIT];
				end
			end else if (wb_adr_i == `MDP_OFS_STATUS) begin
				sw = merge16(status_word, wb_dat_i, wb_sel_i);
				next_st.acc[39:32] = sw[7:0];
				next_st.f_n = sw[`MDP_ST_N_BIT];
				next_st.f_z = sw[`MDP_ST_Z_BIT];
				next_st.f_c = sw[`MDP_ST_C_BIT];
				next_st.f_sv = sw[`MDP_ST_SV_BIT];
				next_st.f_e = sw[`MDP_ST_E_BIT];
				next_st.f_sl = sw[`MDP_ST_SL_BIT];
				next_st.f_v = sw[`MDP_ST_V_BIT];
			end else if (wb_adr_i == `MDP_OFS_ACC_HIGH) begin
				hw = merge16(st.acc[31:16], wb_dat_i, wb_sel_i);
				next_st.acc = {{8{hw[15]}}, hw, 16'h0000}; // RQ20
			end else if (wb_adr_i == `MDP_OFS_ACC_LOW) begin
				next_st.acc[15:0] = merge16(st.acc[15:0], wb_dat_i,
					wb_sel_i);
			end else if (wb_adr_i == `MDP_OFS_OPND_A) begin
				next_st.opa = merge16(st.opa, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `MDP_OFS_OPND_B) begin
				next_st.opb = merge16(st.opb, wb_dat_i, wb_sel_i);
			end
		end
		if (arith || op == MDP_OP_SHIFT) begin
			next_st.acc = res;
			next_st.f_e = ext_used(res); // RQ19 RQ17
			next_st.f_n = res[39]; // RQ22
			next_st.f_z = (res == 40'h0000000000);
			next_st.f_c = carry;
			next_st.f_v = ovf;
			// sticky: an operation can only set them; a status write sets or clears them
			next_st.f_sv = st.f_sv | ovf; // RQ17
			next_st.f_sl = st.f_sl | sat; // RQ17
		end else if (op == MDP_OP_LOAD) begin
			next_st.acc = cat_op; // RQ8
			next_st.f_e = ext_used(cat_op);
			next_st.f_n = cat_op[39];
			next_st.f_z = (cat_op == 40'h0000000000);
			next_st.f_c = 1'b0;
			next_st.f_v = 1'b0;
		end else if (op == MDP_OP_STORE) begin
			// accumulator and flags deliberately left alone
			next_st.store = limited; // RQ15
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdata;

endmodule // mdp_mac_datapath

// *** design/mdp_pkg.sv ***
package mdp_pkg;

	typedef enum logic [3:0] {
		MDP_OP_NOP,
		MDP_OP_MUL,
		MDP_OP_MAC,
		MDP_OP_MSUB,
		MDP_OP_CADD,
		MDP_OP_CSUB,
		MDP_OP_LOAD,
		MDP_OP_SHIFT,
		MDP_OP_STORE
	} mdp_op_t;

	typedef struct packed {
		logic mp;
		logic ms;
		logic [39:0] acc;
		logic f_n;
		logic f_z;
		logic f_c;
		logic f_sv;
		logic f_e;
		logic f_sl;
		logic f_v;
		logic [15:0] opa;
		logic [15:0] opb;
		logic [15:0] store;
		logic ack;
		logic [31:0] rdata;
	} mdp_state_t;

endpackage

// *** sim/mdp_cpu_model.sv ***
`timescale 1ns/10ps
// ****
// cpu side bus master
// ****
module mdp_cpu_model (
	input wire logic core_clk_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_cyc_o = 1'b0,
	output logic wb_stb_o = 1'b0,
	output logic wb_we_o = 1'b0,
	output logic [7:0] wb_adr_o = 8'h00,
	output logic [31:0] wb_dat_o = 32'h00000000,
	output logic [3:0] wb_sel_o = 4'h0
);
	// request held until ack is sampled, then a gap cycle
	task automatic xfer(input logic [7:0] a, input logic [31:0] d,
		input logic w, output logic [31:0] q);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= w;
		wb_adr_o <= a;
		wb_dat_o <= d;
		wb_sel_o <= 4'hF;
		do @(posedge core_clk_i); while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// stale data must not look valid
		wb_dat_o <= ~d;
		@(posedge core_clk_i);
	endtask
endmodule // mdp_cpu_model

// *** sim/mdp_mac_datapath_tb.sv ***
`timescale 1ns/10ps
`define CMP(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
// ****
// testbench
// ****
module mdp_mac_datapath_tb;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rv;
	logic [3:0] wb_sel_i;
	int n_fail = 0;
	int checked = 0;
	always #50 core_clk_i = ~core_clk_i;
	mdp_mac_datapath mdp_mac_datapath_inst (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	mdp_cpu_model mdp_cpu_model_inst (.core_clk_i(core_clk_i),
		.wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
		.wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
		.wb_dat_o(wb_dat_i), .wb_sel_o(wb_sel_i));
	task automatic w(input logic [7:0] a, input logic [15:0] d);
		mdp_cpu_model_inst.xfer(a, {16'h0000, d}, 1'b1, rv);
	endtask
	task automatic rd(input logic [7:0] a);
		mdp_cpu_model_inst.xfer(a, 32'h00000000, 1'b0, rv);
	endtask
	task automatic ck(input string n, input logic [7:0] a,
		input logic [15:0] e);
		rd(a);
		`CMP(n, {16'h0000, e}, rv)
	endtask
	// operands, then the command word
	task automatic run(input logic [15:0] a, b, c);
		w(8'h10, a);
		w(8'h14, b);
		w(8'h18, c);
	endtask
	task automatic stop_test();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_reset();
		ck("ctrl", 8'h00, 16'h0000);
		ck("acc hi", 8'h08, 16'h0000);
		w(8'h00, 16'hFFFF);
		ck("ctrl rw", 8'h00, 16'h0600);
		ck("unmapped", 8'h40, 16'h0000);
		$display("reset test done");
	endtask
	task automatic t_mul();
		w(8'h00, 16'h0000);
		run(16'h8000, 16'h8000, 16'h0031);
		ck("mul", 8'h08, 16'h4000);
		w(8'h00, 16'h0400);
		run(16'h8000, 16'h8000, 16'h0031);
		ck("mul frac", 8'h08, 16'h8000);
		rd(8'h04);
		`CMP("ext flag", 1'b1, rv[12])
		run(16'h4000, 16'h4000, 16'h0031);
		ck("frac q", 8'h08, 16'h2000);
		run(16'hFFFF, 16'hFFFF, 16'h0001);
		ck("uns hi", 8'h08, 16'hFFFE);
		ck("uns lo", 8'h0C, 16'h0001);
		run(16'hFFFF, 16'h0002, 16'h0011);
		ck("mix lo", 8'h0C, 16'hFFFE);
		rd(8'h04);
		`CMP("mix ext", 8'hFF, rv[7:0])
		`CMP("neg", 1'b1, rv[8])
		$display("multiply test done");
	endtask
	task automatic t_rnd();
		w(8'h00, 16'h0000);
		w(8'h0C, 16'h1111);
		w(8'h08, 16'h8000);
		ck("hi clr", 8'h0C, 16'h0000);
		rd(8'h04);
		`CMP("hi sext", 8'hFF, rv[7:0])
		w(8'h08, 16'h1234);
		w(8'h0C, 16'h8000);
		run(16'h0000, 16'h0000, 16'h0042);
		ck("rnd hi", 8'h08, 16'h1235);
		ck("rnd lo", 8'h0C, 16'h0000);
		w(8'h00, 16'h0200);
		w(8'h08, 16'h7FFF);
		w(8'h0C, 16'hFFFF);
		run(16'h0000, 16'h0000, 16'h0042);
		ck("rs hi", 8'h08, 16'h7FFF);
		ck("rs lo", 8'h0C, 16'hFFFF);
		run(16'h1234, 16'h1234, 16'h0006);
		ck("load", 8'h08, 16'h1234);
		$display("round test done");
	endtask
	task automatic t_sat();
		w(8'h08, 16'h7FFF);
		w(8'h0C, 16'hFFFF);
		run(16'h0001, 16'h0001, 16'h0004);
		ck("sat hi", 8'h08, 16'h7FFF);
		ck("sat lo", 8'h0C, 16'hFFFF);
		w(8'h08, 16'h8000);
		run(16'h0001, 16'h0001, 16'h0005);
		ck("satn hi", 8'h08, 16'h8000);
		ck("satn lo", 8'h0C, 16'h0000);
		rd(8'h04);
		`CMP("sticky lim", 1'b1, rv[13])
		w(8'h00, 16'h0000);
		w(8'h08, 16'h0001);
		run(16'h0001, 16'h0001, 16'h0084);
		ck("cat hi", 8'h08, 16'h0003);
		ck("cat lo", 8'h0C, 16'h0002);
		// -1 times 1 subtracted: product must arrive sign-extended
		run(16'hFFFF, 16'h0001, 16'h0033);
		ck("msub lo", 8'h0C, 16'h0003);
		rd(8'h04);
		`CMP("msub ext", 8'h00, rv[7:0])
		$display("saturate test done");
	endtask
	task automatic t_lim();
		w(8'h08, 16'h7FFF);
		w(8'h0C, 16'hFFFF);
		run(16'h0001, 16'h0001, 16'h0004);
		run(16'h0000, 16'h0000, 16'h0008);
		ck("lim pos", 8'h1C, 16'h7FFF);
		ck("lim acc", 8'h08, 16'h8001);
		w(8'h08, 16'h8000);
		run(16'h0001, 16'h0001, 16'h0005);
		run(16'h0000, 16'h0000, 16'h0008);
		ck("lim neg", 8'h1C, 16'h8000);
		w(8'h08, 16'h1234);
		// flags survive a high-word write; clear the stale extension flag
		w(8'h04, 16'h0000);
		run(16'h0000, 16'h0000, 16'h0008);
		ck("lim none", 8'h1C, 16'h1234);
		$display("limit test done");
	endtask
	task automatic t_shf();
		w(8'h08, 16'h0001);
		run(16'h0000, 16'h0000, 16'h2007);
		rd(8'h04);
		`CMP("shl ext", 8'h01, rv[7:0])
		`CMP("shl flag", 1'b1, rv[12])
		w(8'h08, 16'h8000);
		run(16'h0000, 16'h0000, 16'h2107);
		ck("shr hi", 8'h08, 16'hFFFF);
		ck("shr lo", 8'h0C, 16'h8000);
		w(8'h00, 16'h0200);
		w(8'h08, 16'h4000);
		run(16'h0000, 16'h0000, 16'h0207);
		ck("shl sat", 8'h0C, 16'hFFFF);
		$display("shift test done");
	endtask
	// generous: about 120 transfers of three cycles each
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset();
		t_mul();
		t_rnd();
		t_sat();
		t_lim();
		t_shf();
		stop_test();
	end
endmodule // mdp_mac_datapath_tb

// *** sim/mdp_monitor.sv ***
`timescale 1ns/10ps
// ****
// bus-side checks
// ****
module mdp_monitor (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic rd = wb_ack_o && !wb_we_i;
	sequence s_hi_wr;
		wb_ack_o && wb_we_i && wb_adr_i == 8'h08;
	endsequence
	sequence s_lo_rd;
		req && !wb_we_i && wb_adr_i == 8'h0C;
	endsequence
	a_ack_follows: assert property (req |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
		else $error("ack without request");
	a_upper_zero: assert property (rd |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_cmd_zero: assert property (rd && wb_adr_i == 8'h18 |-> !wb_dat_o)
		else $error("command reads nonzero");
	a_ctrl_rsvd: assert property (rd && wb_adr_i == 8'h00
		|-> {wb_dat_o[15:11], wb_dat_o[8:0]} == 14'h0000)
		else $error("control reserved bits set");
	a_data_hold: assert property (!req |=> $stable(wb_dat_o))
		else $error("read data moved");
	a_hi_clears: assert property (s_hi_wr ##2 s_lo_rd |=> !wb_dat_o)
		else $error("low word kept");
endmodule // mdp_monitor

bind mdp_mac_datapath mdp_monitor mdp_monitor_inst (
	.core_clk_i(core_clk_i),
	.rstn_i(rstn_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o)
);
